// ---- core/wwd_params.svh ----
/*
 Constants of the window watchdog supervisor: clock rate, time base,
 preset window and reset delay times, register offsets and event bits.
 Assumes it is included by bare name before any user of the macros.
*/
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Clock and time base
`define WWD_CLK_PERIOD_NS 4
`define WWD_TICK_NS 1000
// Least time per tick, so round the cycle count up
`define WWD_TICK_CYC ((`WWD_TICK_NS + `WWD_CLK_PERIOD_NS - 1) / `WWD_CLK_PERIOD_NS)
`define WWD_DIV_W 16
`define WWD_CNT_W 24

////////////////////////////////////////////////////////////////////////////////
// Preset times in microseconds
`define WWD_T_RST_OPEN_US 200000
`define WWD_T_RST_PULL_US 10000
`define WWD_WINDOW_LOWER_BOUND_00_US 22500
`define WWD_WINDOW_LOWER_BOUND_01_US 1850
`define WWD_WINDOW_LOWER_BOUND_11_US 800000
`define WWD_PRESET_UPPER_MUL 2

////////////////////////////////////////////////////////////////////////////////
// Register map and reset values
`define WWD_ADDR_W 8
`define WWD_REG_UPPER 8'h00
`define WWD_REG_RSTDLY 8'h04
`define WWD_REG_STATUS 8'h08
`define WWD_REG_MASK 8'h0C
`define WWD_REG_STATE 8'h10
`define WWD_UPPER_RST 24'h00F424
`define WWD_RSTDLY_RST 24'h002710

////////////////////////////////////////////////////////////////////////////////
// Event bits of status and mask
`define WWD_EV_W 3
`define WWD_EV_LATE 0
`define WWD_EV_EARLY 1
`define WWD_EV_RELEASE 2

`endif

// ---- core/wwd_pkg.sv ----
/*
 Types of the window watchdog supervisor: pin strap modes, supervisor
 states and the packed state records of both modules.
 Assumes wwd_params.svh is reachable on the include path.
*/
`include "wwd_params.svh"

package wwd_pkg;

   // Strap seen on a timing pin
   typedef enum logic [1:0] {
      WWD_PIN_OPEN = 2'b00,
      WWD_PIN_PULLUP = 2'b01,
      WWD_PIN_CAP = 2'b10
   } wwd_pin_mode_t;

   // Supervisor sequence
   typedef enum logic [2:0] {
      WWD_ST_POWERUP = 3'b000,
      WWD_ST_WINDOW = 3'b001,
      WWD_ST_FAULT = 3'b010,
      WWD_ST_DISABLED = 3'b011
   } wwd_state_t;

   typedef struct packed {
      logic [`WWD_DIV_W-1:0] div;
      logic tick;
   } wwd_tick_regs_t;

   typedef struct packed {
      wwd_state_t st;
      logic [`WWD_CNT_W-1:0] cnt;
      logic wdi_q;
      logic [`WWD_CNT_W-1:0] upper_cfg;
      logic [`WWD_CNT_W-1:0] rstdly_cfg;
      logic [`WWD_EV_W-1:0] status;
      logic [`WWD_EV_W-1:0] mask;
      logic [31:0] rdata;
      logic irq;
      logic oe_n;
      logic pin_o;
   } wwd_regs_t;

endpackage

// ---- core/wwd_tick_gen.sv ----
/*
 Time base of the supervisor: one-cycle tick every TICK_CYC enabled cycles.
 Assumes one clock, asynchronous active-low reset and a freezing enable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wwd_params.svh"

module wwd_tick_gen
   import wwd_pkg::*;
#(
   parameter int TICK_CYC = `WWD_TICK_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   output logic tick
);

   wwd_tick_regs_t r_ff;
   wwd_tick_regs_t nxt_r;

   ////////////////////////////////////////////////////////////////////////////
   // Divider; the tick drops while the enable is low so nothing advances
   always_comb begin
      nxt_r = r_ff;
      if (ce) begin
         if (r_ff.div >= `WWD_DIV_W'(TICK_CYC - 1)) begin
            nxt_r.div = '0;
            nxt_r.tick = 1'b1;
         end else begin
            nxt_r.div = r_ff.div + 1'b1;
            nxt_r.tick = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign tick = r_ff.tick & ce;

endmodule
`default_nettype wire

// ---- core/wwd_supervisor.sv ----
/*
 Window watchdog supervisor: checks service falling edges against a
 window, drives an active-low open-drain fault output for a reset delay,
 and offers a small register port with sticky events and an interrupt.
 Assumes pins synchronous to CLK, an external pull-up on the fault pin
 and a master that follows the one-cycle strobe protocol.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wwd_params.svh"

module wwd_supervisor
   import wwd_pkg::*;
#(
   parameter int TICK_CYC = `WWD_TICK_CYC,
   parameter logic [`WWD_CNT_W-1:0] T_RST_OPEN =
      `WWD_CNT_W'(`WWD_T_RST_OPEN_US * 1000 / `WWD_TICK_NS),
   parameter logic [`WWD_CNT_W-1:0] T_RST_PULL =
      `WWD_CNT_W'(`WWD_T_RST_PULL_US * 1000 / `WWD_TICK_NS),
   parameter logic [`WWD_CNT_W-1:0] WINDOW_LOWER_BOUND_00 =
      `WWD_CNT_W'(`WWD_WINDOW_LOWER_BOUND_00_US * 1000 / `WWD_TICK_NS),
   parameter logic [`WWD_CNT_W-1:0] WINDOW_LOWER_BOUND_01 =
      `WWD_CNT_W'(`WWD_WINDOW_LOWER_BOUND_01_US * 1000 / `WWD_TICK_NS),
   parameter logic [`WWD_CNT_W-1:0] WINDOW_LOWER_BOUND_11 =
      `WWD_CNT_W'(`WWD_WINDOW_LOWER_BOUND_11_US * 1000 / `WWD_TICK_NS),
   parameter int UPPER_MUL = `WWD_PRESET_UPPER_MUL
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic SERVICE_PULSE_IN,
   input wire logic WINDOW_SEL_LO,
   input wire logic WINDOW_SEL_HI,
   input wire logic [1:0] TIMEOUT_CAP_PIN,
   input wire logic [1:0] DELAY_CAP_PIN,
   input wire logic FAULT_RESET_OUT_I,
   output logic FAULT_RESET_OUT_O,
   output logic FAULT_RESET_OUT_OE_N,
   input wire logic [`WWD_ADDR_W-1:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic IRQ
);

   localparam int CW = `WWD_CNT_W;

   wwd_regs_t r_ff;
   wwd_regs_t nxt_r;
   logic tick;
   logic dis;
   logic fall;
   logic [CW-1:0] lower_b;
   logic [CW-1:0] upper_b;
   logic [CW-1:0] dly_b;
   logic [`WWD_EV_W-1:0] ev_set;
   logic [`WWD_EV_W-1:0] ev_clr;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Lower bound as a fraction of a programmed upper bound
   function automatic logic [CW-1:0] wwd_frac(input logic [CW-1:0] u,
                                              input logic s_lo,
                                              input logic s_hi);
      logic [CW-1:0] f;
      f = u >> 3;
      if (s_lo && s_hi) begin
         f = u >> 1;
      end else if (!s_lo && s_hi) begin
         f = u - (u >> 2);
      end
      return f;
   endfunction

   // Preset lower bound for a select pair; a disabling pair falls back to 00
   function automatic logic [CW-1:0] wwd_preset(input logic s_lo,
                                                input logic s_hi);
      logic [CW-1:0] p;
      p = WINDOW_LOWER_BOUND_00;
      if (s_lo && s_hi) begin
         p = WINDOW_LOWER_BOUND_11;
      end else if (!s_lo && s_hi) begin
         p = WINDOW_LOWER_BOUND_01;
      end
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Time base
   wwd_tick_gen #(
      .TICK_CYC(TICK_CYC)
   ) u_tick (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Strap and select decoding
   // Disable decode
   assign dis = (TIMEOUT_CAP_PIN == WWD_PIN_OPEN) && WINDOW_SEL_LO && !WINDOW_SEL_HI;

   always_comb begin
      if (TIMEOUT_CAP_PIN == WWD_PIN_CAP) begin
         upper_b = r_ff.upper_cfg;
         lower_b = wwd_frac(r_ff.upper_cfg, WINDOW_SEL_LO, WINDOW_SEL_HI);
      end else begin
         lower_b = wwd_preset(WINDOW_SEL_LO, WINDOW_SEL_HI);
         upper_b = CW'(lower_b * UPPER_MUL);
      end
   end

   // Reset delay from the delay strap
   always_comb begin
      if (DELAY_CAP_PIN == WWD_PIN_CAP) begin
         dly_b = r_ff.rstdly_cfg;
      end else if (DELAY_CAP_PIN == WWD_PIN_PULLUP) begin
         dly_b = T_RST_PULL;
      end else begin
         dly_b = T_RST_OPEN;
      end
   end

   // Service edge against the previous sample
   assign fall = r_ff.wdi_q && !SERVICE_PULSE_IN;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: sequence, events, register port
   always_comb begin
      nxt_r = r_ff;
      ev_set = '0;
      ev_clr = '0;
      if (CE) begin
         nxt_r.wdi_q = SERVICE_PULSE_IN;
         case (r_ff.st)
            WWD_ST_POWERUP: begin
               if (r_ff.cnt >= dly_b) begin
                  nxt_r.st = WWD_ST_WINDOW;
                  nxt_r.cnt = '0;
               end else if (tick) begin
                  nxt_r.cnt = r_ff.cnt + 1'b1;
               end
            end
            WWD_ST_WINDOW: begin
               if (fall && (r_ff.cnt < lower_b)) begin
                  nxt_r.st = WWD_ST_FAULT;
                  nxt_r.cnt = '0;
                  ev_set[`WWD_EV_EARLY] = 1'b1;
               end else if (fall) begin
                  nxt_r.cnt = '0;
               end else if (r_ff.cnt >= upper_b) begin
                  nxt_r.st = WWD_ST_FAULT;
                  nxt_r.cnt = '0;
                  ev_set[`WWD_EV_LATE] = 1'b1;
               end else if (tick) begin
                  nxt_r.cnt = r_ff.cnt + 1'b1;
               end
            end
            WWD_ST_FAULT: begin
               if (r_ff.cnt >= dly_b) begin
                  nxt_r.st = WWD_ST_WINDOW;
                  nxt_r.cnt = '0;
                  ev_set[`WWD_EV_RELEASE] = 1'b1;
               end else if (tick) begin
                  nxt_r.cnt = r_ff.cnt + 1'b1;
               end
            end
            default: begin
               // Leaving disable starts a fresh window
               nxt_r.st = WWD_ST_WINDOW;
               nxt_r.cnt = '0;
            end
         endcase
         if (dis) begin
            nxt_r.st = WWD_ST_DISABLED;
            nxt_r.cnt = '0;
         end
         // Register writes
         if (REG_WR) begin
            if (REG_ADDR == `WWD_REG_UPPER) begin
               nxt_r.upper_cfg = REG_WDATA[CW-1:0];
            end else if (REG_ADDR == `WWD_REG_RSTDLY) begin
               nxt_r.rstdly_cfg = REG_WDATA[CW-1:0];
            end else if (REG_ADDR == `WWD_REG_STATUS) begin
               ev_clr = REG_WDATA[`WWD_EV_W-1:0];
            end else if (REG_ADDR == `WWD_REG_MASK) begin
               nxt_r.mask = REG_WDATA[`WWD_EV_W-1:0];
            end
         end
         // Set wins over a write-one clear in the same cycle
         nxt_r.status = (r_ff.status & ~ev_clr) | ev_set;
         // Read data stand for one enabled cycle only; unmapped reads give zero
         nxt_r.rdata = '0;
         if (REG_RD) begin
            if (REG_ADDR == `WWD_REG_UPPER) begin
               nxt_r.rdata = {8'h00, r_ff.upper_cfg};
            end else if (REG_ADDR == `WWD_REG_RSTDLY) begin
               nxt_r.rdata = {8'h00, r_ff.rstdly_cfg};
            end else if (REG_ADDR == `WWD_REG_STATUS) begin
               nxt_r.rdata = {29'h0, r_ff.status};
            end else if (REG_ADDR == `WWD_REG_MASK) begin
               nxt_r.rdata = {29'h0, r_ff.mask};
            end else if (REG_ADDR == `WWD_REG_STATE) begin
               nxt_r.rdata = {r_ff.cnt, 2'h0, FAULT_RESET_OUT_I, r_ff.oe_n, dis, r_ff.st};
            end
         end
         nxt_r.oe_n = (nxt_r.st != WWD_ST_FAULT);
         nxt_r.pin_o = 1'b0;
         nxt_r.irq = |(nxt_r.status & nxt_r.mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; the pin is released from reset on
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         r_ff <= '0;
         r_ff.st <= WWD_ST_POWERUP;
         r_ff.upper_cfg <= `WWD_UPPER_RST;
         r_ff.rstdly_cfg <= `WWD_RSTDLY_RST;
         r_ff.oe_n <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Outputs straight from the state register
   assign FAULT_RESET_OUT_O = r_ff.pin_o;
   assign FAULT_RESET_OUT_OE_N = r_ff.oe_n;
   assign REG_RDATA = r_ff.rdata;
   assign IRQ = r_ff.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   chk_powerup_ignore: assert property (
      (r_ff.st == WWD_ST_POWERUP) && CE && !dis && (r_ff.cnt < dly_b)
      |=> (r_ff.st == WWD_ST_POWERUP) && FAULT_RESET_OUT_OE_N)
      else $error("service edge acted during power-up");

   chk_fault_hold: assert property (
      (r_ff.st == WWD_ST_FAULT) && CE && !dis && (r_ff.cnt < dly_b)
      |=> (r_ff.st == WWD_ST_FAULT) && (r_ff.cnt >= $past(r_ff.cnt)))
      else $error("fault interval cut or restarted");

   chk_disable_ignore: assert property (
      dis && CE |=> (r_ff.st == WWD_ST_DISABLED) && (r_ff.cnt == '0))
      else $error("window checked while disabled");

   chk_timeout_fault: assert property (
      (r_ff.st == WWD_ST_WINDOW) && CE && !dis && !fall && (r_ff.cnt >= upper_b)
      |=> !FAULT_RESET_OUT_OE_N && r_ff.status[`WWD_EV_LATE])
      else $error("late timeout did not pull fault low");

   chk_open_drain: assert property (
      !FAULT_RESET_OUT_O && (FAULT_RESET_OUT_OE_N == (r_ff.st != WWD_ST_FAULT)))
      else $error("fault pin drive does not match state");

   chk_disabled_high: assert property (
      (r_ff.st == WWD_ST_DISABLED) |-> FAULT_RESET_OUT_OE_N && !FAULT_RESET_OUT_O)
      else $error("fault driven while disabled");

   chk_sel_decode: assert property (
      CE && !((TIMEOUT_CAP_PIN == WWD_PIN_OPEN) && WINDOW_SEL_LO && !WINDOW_SEL_HI)
      |=> (r_ff.st != WWD_ST_DISABLED))
      else $error("watchdog disabled by a non-disabling select pair");

   chk_ratio_tq: assert property (
      (TIMEOUT_CAP_PIN == WWD_PIN_CAP) && !WINDOW_SEL_LO && WINDOW_SEL_HI
      |-> (lower_b == r_ff.upper_cfg - (r_ff.upper_cfg >> 2)))
      else $error("window ratio wrong");

   chk_early_edge: assert property (
      (r_ff.st == WWD_ST_WINDOW) && CE && !dis && fall && (r_ff.cnt < lower_b)
      |=> (r_ff.st == WWD_ST_FAULT) && r_ff.status[`WWD_EV_EARLY] ##1 !FAULT_RESET_OUT_OE_N)
      else $error("early edge not treated as timeout");

   chk_valid_restart: assert property (
      (r_ff.st == WWD_ST_WINDOW) && CE && !dis && fall && (r_ff.cnt >= lower_b)
      |=> (r_ff.st == WWD_ST_WINDOW) && (r_ff.cnt == '0))
      else $error("valid edge did not restart window");

   chk_release_restart: assert property (
      (r_ff.st == WWD_ST_FAULT) && CE && !dis && (r_ff.cnt >= dly_b)
      |=> (r_ff.st == WWD_ST_WINDOW) && (r_ff.cnt == '0) && FAULT_RESET_OUT_OE_N)
      else $error("release did not restart window");

   // Release only once the delay has run out; disable may cut it short
   chk_release_late: assert property (
      $rose(FAULT_RESET_OUT_OE_N) && ($past(r_ff.st) == WWD_ST_FAULT) && !$past(dis)
      |-> ($past(r_ff.cnt) >= $past(dly_b)))
      else $error("fault released before its delay");

   // Enable low freezes the sequence and the interrupt
   chk_ce_freeze: assert property (
      !CE |=> (r_ff.st == $past(r_ff.st)) && (r_ff.cnt == $past(r_ff.cnt)) && $stable(IRQ))
      else $error("state moved while enable low");

   // Read data stand for a single enabled cycle only
   chk_rdata_once: assert property (
      CE && !REG_RD |=> (REG_RDATA == '0))
      else $error("read data outlived their cycle");

endmodule
`default_nettype wire

// ---- verification/wwd_host_model.sv ----
/*
 Host model: on a kick it raises the service line, holds it for a set
 number of cycles and then drops it, giving one falling edge.
 Assumes the bench kicks only while the model is idle.
*/
`timescale 1ns/10ps
`default_nettype none

module wwd_host_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic kick,
   input wire logic [15:0] hold_cyc,
   output logic service,
   output logic busy
);
   logic [15:0] left_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Timed fall, driven level
   // The line is never left floating, so a disabled device still sees a level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         service <= 1'b0;
         busy <= 1'b0;
         left_ff <= 16'h0000;
      end else if (kick) begin
         service <= 1'b1;
         busy <= 1'b1;
         left_ff <= hold_cyc;
      end else if (left_ff != 16'h0000) begin
         left_ff <= left_ff - 16'h0001;
      end else begin
         service <= 1'b0;
         busy <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// ---- verification/tb_wwd_supervisor.sv ----
/*
 Testbench of the window watchdog supervisor: reset values, power-up,
 preset and capacitor windows, disable, fault length and events.
 Assumes the design files and the host model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wwd_params.svh"

module tb_wwd_supervisor
   import wwd_pkg::*;
;
   localparam int TCYC = 2;
   // Mode code is {timeout strap, second select, first select}
   localparam logic [3:0] MODE [6] = '{4'h0, 4'h2, 4'h3, 4'h8, 4'hA, 4'hB};
   localparam int EARLY [6] = '{10, 5, 25, 3, 42, 28};
   localparam int GOOD [6] = '{30, 15, 45, 12, 56, 40};

   logic clk, nrst, svc, sel_lo, sel_hi, pin_i, pin_o, oe_n, irq, kick, busy;
   logic reg_wr, reg_rd, fault_seen, ce;
   logic [1:0] tcap, dcap;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] hold;
   int miscompares = 0;
   int tests_run = 0;
   int low_len = 0;
   int last_len = 0;
   int exp_dly = 10;

   ////////////////////////////////////////////////////////////////////////////////
   // Pull-up on the fault pin; the device only ever sinks
   assign pin_i = oe_n ? 1'b1 : pin_o;

   wwd_supervisor #(.TICK_CYC(TCYC), .T_RST_PULL(24'h00000A),
      .WINDOW_LOWER_BOUND_00(24'h000014), .WINDOW_LOWER_BOUND_01(24'h00000A), .WINDOW_LOWER_BOUND_11(24'h00001E)) u_wwd_supervisor (
      .CLK(clk), .NRST(nrst), .CE(ce), .SERVICE_PULSE_IN(svc),
      .WINDOW_SEL_LO(sel_lo), .WINDOW_SEL_HI(sel_hi), .TIMEOUT_CAP_PIN(tcap),
      .DELAY_CAP_PIN(dcap), .FAULT_RESET_OUT_I(pin_i), .FAULT_RESET_OUT_O(pin_o),
      .FAULT_RESET_OUT_OE_N(oe_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq));

   wwd_host_model u_wwd_host_model (.clk(clk), .nrst(nrst), .kick(kick),
      .hold_cyc(hold), .service(svc), .busy(busy));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One-cycle strobes, data sampled in the cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic wait_state(input logic [2:0] s);
      logic [31:0] d;
      d = 32'h0;
      for (int i = 0; i < 100 && d[2:0] !== s; i++) begin
         rd(`WWD_REG_STATE, d);
      end
      cmp({29'h0, d[2:0]}, {29'h0, s});
   endtask

   // One service edge after the given ticks; waits out any fault it causes
   task automatic run_window(input int ticks, input logic expf);
      int n;
      fault_seen = 1'b0;
      @(posedge clk);
      kick <= 1'b1;
      hold <= 16'(ticks * TCYC);
      @(posedge clk);
      kick <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (busy && n < 400);
      repeat (4) @(posedge clk);
      n = 0;
      while (oe_n !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      repeat (2) @(posedge clk);
      cmp({31'h0, fault_seen}, {31'h0, expf});
      if (expf) begin
         // Fault held for the strap's delay, plus the entry and release cycles
         cmp({31'h0, (last_len - exp_dly * TCYC) inside {[0:4]}}, 32'h1);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Fault pulse length and drive level
   always @(posedge clk) begin
      if (oe_n === 1'b0) begin
         fault_seen <= 1'b1;
         low_len <= low_len + 1;
         cmp({31'h0, pin_o}, 32'h0);
      end else if (low_len != 0) begin
         last_len <= low_len;
         low_len <= 0;
      end
   end

   // Cuts a hang short, far beyond the expected run of a few thousand cycles
   initial begin
      #100000;
      miscompares++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      {nrst, kick, hold, sel_lo, sel_hi, tcap, fault_seen} = '0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      dcap = 2'h1;
      ce = 1'b1;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      run_window(2, 1'b0);
      rd(`WWD_REG_STATE, d);
      cmp({29'h0, d[2:0]}, 32'h0);
      rd(`WWD_REG_UPPER, d);
      cmp(d, 32'h00F424);
      rd(`WWD_REG_RSTDLY, d);
      cmp(d, 32'h002710);
      rd(8'h14, d);
      cmp(d, 32'h0);
      wr(`WWD_REG_UPPER, 32'h00000040);
      rd(`WWD_REG_UPPER, d);
      cmp(d, 32'h00000040);
      // Select pairs 00, 01 and 11 under the open and capacitor straps, entered from disable for a fresh window
      for (int i = 0; i < 6; i++) begin
         {tcap, sel_hi, sel_lo} <= 4'h1;
         wait_state(3'h3);
         run_window(70, 1'b0);
         {tcap, sel_hi, sel_lo} <= MODE[i];
         wait_state(3'h1);
         run_window(EARLY[i], 1'b1);
         run_window(GOOD[i], 1'b0);
         run_window(GOOD[i], 1'b0);
      end
      // Late timeout with an edge landing inside the fault
      wr(`WWD_REG_STATUS, 32'h7);
      #1;
      cmp({31'h0, irq}, 32'h0);
      run_window(66, 1'b1);
      rd(`WWD_REG_STATUS, d);
      cmp(d, 32'h5);
      cmp({31'h0, irq}, 32'h0);
      wr(`WWD_REG_MASK, 32'h1);
      @(posedge clk);
      #1;
      cmp({31'h0, irq}, 32'h1);
      wr(`WWD_REG_STATUS, 32'h1);
      @(posedge clk);
      #1;
      cmp({31'h0, irq}, 32'h0);
      rd(`WWD_REG_STATUS, d);
      cmp(d, 32'h4);
      rd(`WWD_REG_MASK, d);
      cmp(d, 32'h1);
      // Capacitor delay strap takes the programmed delay register
      wr(`WWD_REG_RSTDLY, 32'h0000000C);
      dcap <= 2'h2;
      exp_dly = 12;
      run_window(5, 1'b1);
      // A write made while the enable is low must be refused
      ce <= 1'b0;
      wr(`WWD_REG_MASK, 32'h0);
      ce <= 1'b1;
      rd(`WWD_REG_MASK, d);
      cmp(d, 32'h1);
      close_out();
   end
endmodule

`default_nettype wire
